//--- hdl/dcdl_ctrl.sv
// Delay loop controller for the converter clock path, with its
// configuration registers, search sequencer, lock status and readback.
// Assumes register accesses arrive already decoded from the serial port,
// synchronous to I_CORE_CLK, and that the phase detector flag is synchronous.
//
// Behaviour
// - A power-down bit that resets to 1 powers down the loop controller and digital clock generator.
// - The fine delay line has duty correction and cross control enables, each resetting to 1.
// - The coarse delay line has duty correction and cross control enables, each resetting to 1.
// - A two-bit field picks search down only, up only, or both, and resets to binary 10.
// - With the controller enable at 0 the static coarse setpoint drives the coarse line, at 1 the loop drives it; the fine line stays at its midpoint.
// - Status bit 2 is a read-only flag shown when the loop fails to lock.
// - Status bit 1 is set when a held lock is lost and resets to 0.
// - Status bit 0 is a read-only flag shown while the loop is locked.
// - A writable six-bit coarse setpoint in bits 5 to 0 resets to 0.
// - A 0 to 1 change of the read-request bit captures coarse, fine and phase readback values.
`timescale 1ns/100ps
`default_nettype none
`include "dcdl_params.svh"

module dcdl_ctrl
  import dcdl_pkg::*;
#(
  parameter int STEP_CYC = `DCDL_STEP_CYC,
  parameter int COARSE_W = 6,
  parameter int PHASE_W  = 5
) (
  input  wire logic          I_CORE_CLK,
  input  wire logic          I_RST,
  input  wire dcdl_reg_req_s I_REG_REQ,
  input  wire logic          I_PHASE_MATCH,
  input  wire logic [4:0]    I_PHASE_MEAS,
  output logic [7:0]         O_REG_RDATA,
  output logic               O_REG_RVALID,
  output logic               O_LOOP_PD,
  output var dcdl_line_en_s  O_LINE_EN,
  output logic [5:0]         O_COARSE_DELAY,
  output logic [7:0]         O_FINE_DELAY,
  output logic               O_LOCKED
);

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------
  // The register fields are fixed at six and five bits
  // The step wait counter is sixteen bits wide
  if (COARSE_W != 6 || PHASE_W != 5 || STEP_CYC < 1 || STEP_CYC > 65536) begin : g_bad_param
    $error("dcdl_ctrl: unsupported parameter value");
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // One step of the coarse line, saturating at both ends
  function automatic logic [5:0] dcdl_step(input logic [5:0] val, input logic up);
    logic [5:0] res;
    res = val;
    if (up && val != 6'h3f) begin
      res = val + 6'h01;
    end else if (!up && val != 6'h00) begin
      res = val - 6'h01;
    end
    return res;
  endfunction : dcdl_step

  // --------------------------------------------------------------------
  // Registers and next values
  // --------------------------------------------------------------------
  logic [4:0]  pwr_ff;
  logic [7:0]  ctrl_ff;
  logic [3:0]  guard_ff;
  logic [5:0]  coarse_sp_ff;
  logic        rd_req_ff;
  logic [5:0]  rb_crs_ff;
  logic [7:0]  rb_fine_ff;
  logic [4:0]  rb_phs_ff;
  logic        lost_ff;
  logic        fail_ff;
  logic        locked_ff;
  dcdl_state_e state_ff;
  dcdl_state_e nxt_state;
  logic [5:0]  loop_crs_ff;
  logic [5:0]  nxt_loop_crs;
  logic [5:0]  origin_ff;
  logic [15:0] wait_ff;
  logic [15:0] nxt_wait;
  logic [7:0]  rdata_ff;
  logic        rvalid_ff;
  logic [5:0]  coarse_out_ff;
  logic [7:0]  fine_out_ff;
  logic        lost_set;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire logic wr_pwr    = I_REG_REQ.wr && I_REG_REQ.addr == `DCDL_ADDR_PWR;
  wire logic wr_ctrl   = I_REG_REQ.wr && I_REG_REQ.addr == `DCDL_ADDR_CTRL;
  wire logic wr_stat   = I_REG_REQ.wr && I_REG_REQ.addr == `DCDL_ADDR_STAT;
  wire logic wr_guard  = I_REG_REQ.wr && I_REG_REQ.addr == `DCDL_ADDR_GUARD;
  wire logic wr_coarse = I_REG_REQ.wr && I_REG_REQ.addr == `DCDL_ADDR_COARSE;
  wire logic wr_read   = I_REG_REQ.wr && I_REG_REQ.addr == `DCDL_ADDR_READ;

  // Controller runs only when enabled and powered up
  wire logic       loop_pd  = pwr_ff[`DCDL_PWR_PD_BIT];
  wire logic       loop_en  = ctrl_ff[`DCDL_CTRL_EN_BIT];
  wire logic       run      = loop_en && !loop_pd;
  wire logic [1:0] srch_dir = ctrl_ff[`DCDL_CTRL_SRCH_LO +: 2];
  wire logic       step_due = wait_ff == 16'h0000;
  wire logic [7:0] stat_rd  = {5'h00, fail_ff, lost_ff, locked_ff};

  // Readback capture on the rising edge of the request bit
  wire logic rd_rise = wr_read && I_REG_REQ.wdata[0] && !rd_req_ff;

  // --------------------------------------------------------------------
  // Read data mux
  // --------------------------------------------------------------------
  // Reserved bits and unmapped offsets read as zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (I_REG_REQ.addr)
      `DCDL_ADDR_PWR:     rd_mux = {3'h0, pwr_ff};
      `DCDL_ADDR_CTRL:    rd_mux = ctrl_ff;
      `DCDL_ADDR_STAT:    rd_mux = stat_rd;
      `DCDL_ADDR_GUARD:   rd_mux = {4'h0, guard_ff};
      `DCDL_ADDR_COARSE:  rd_mux = {2'h0, coarse_sp_ff};
      `DCDL_ADDR_READ:    rd_mux = {7'h00, rd_req_ff};
      `DCDL_ADDR_RB_CRS:  rd_mux = {2'h0, rb_crs_ff};
      `DCDL_ADDR_RB_FINE: rd_mux = rb_fine_ff;
      `DCDL_ADDR_RB_PHS:  rd_mux = {3'h0, rb_phs_ff};
      default:            rd_mux = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  // Power and line enables
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      pwr_ff <= `DCDL_RST_PWR;
    end else if (wr_pwr) begin
      pwr_ff <= I_REG_REQ.wdata[4:0];
    end
  end

  // Control register; error, slope and mode fields are stored only
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_ff <= `DCDL_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_ff <= I_REG_REQ.wdata;
    end
  end

  // Guard band and coarse setpoint
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      guard_ff     <= `DCDL_RST_GUARD;
      coarse_sp_ff <= `DCDL_RST_COARSE;
    end else begin
      if (wr_guard) guard_ff <= I_REG_REQ.wdata[3:0];
      if (wr_coarse) coarse_sp_ff <= I_REG_REQ.wdata[5:0];
    end
  end

  // Read request bit and readback captures
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rd_req_ff  <= 1'b0;
      rb_crs_ff  <= 6'h00;
      rb_fine_ff <= 8'h00;
      rb_phs_ff  <= 5'h00;
    end else begin
      if (wr_read) rd_req_ff <= I_REG_REQ.wdata[0];
      if (rd_rise) begin
        rb_crs_ff  <= coarse_out_ff;
        rb_fine_ff <= `DCDL_FINE_FIXED;
        rb_phs_ff  <= I_PHASE_MEAS;
      end
    end
  end

  // --------------------------------------------------------------------
  // Search and track sequencer
  // --------------------------------------------------------------------
  // Both-way search walks down to zero first, then up from the origin.
  // Each step waits STEP_CYC cycles so the line can settle before judging.
  always_comb begin
    nxt_state    = state_ff;
    nxt_loop_crs = loop_crs_ff;
    nxt_wait     = step_due ? 16'h0000 : wait_ff - 16'h0001;
    case (state_ff)
      ST_IDLE: begin
        nxt_loop_crs = coarse_sp_ff;
        nxt_wait     = 16'(STEP_CYC - 1);
        if (run) begin
          nxt_state = (srch_dir == `DCDL_SRCH_UP) ? ST_UP : ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (step_due) begin
          nxt_wait = 16'(STEP_CYC - 1);
          if (I_PHASE_MATCH) begin
            nxt_state = ST_LOCK;
          end else if (loop_crs_ff != 6'h00) begin
            nxt_loop_crs = dcdl_step(loop_crs_ff, 1'b0);
          end else if (srch_dir == `DCDL_SRCH_DN) begin
            nxt_state = ST_FAIL;
          end else begin
            nxt_state    = ST_UP;
            nxt_loop_crs = origin_ff;
          end
        end
      end
      ST_UP: begin
        if (step_due) begin
          nxt_wait = 16'(STEP_CYC - 1);
          if (I_PHASE_MATCH) begin
            nxt_state = ST_LOCK;
          end else if (loop_crs_ff != 6'h3f) begin
            nxt_loop_crs = dcdl_step(loop_crs_ff, 1'b1);
          end else begin
            nxt_state = ST_FAIL;
          end
        end
      end
      ST_LOCK: begin
        if (!I_PHASE_MATCH) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_FAIL: begin
        nxt_state = ST_FAIL;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Leaving loop mode or powering down abandons any search
    if (!run) begin
      nxt_state = ST_IDLE;
    end
  end

  // Sequencer state
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_ff    <= ST_IDLE;
      loop_crs_ff <= `DCDL_RST_COARSE;
      origin_ff   <= `DCDL_RST_COARSE;
      wait_ff     <= 16'h0000;
    end else begin
      state_ff    <= nxt_state;
      loop_crs_ff <= nxt_loop_crs;
      wait_ff     <= nxt_wait;
      if (state_ff == ST_IDLE) origin_ff <= coarse_sp_ff;
    end
  end

  // --------------------------------------------------------------------
  // Lock status
  // --------------------------------------------------------------------
  // A held lock dropping counts as lost; set wins over a software clear
  assign lost_set = state_ff == ST_LOCK && !I_PHASE_MATCH && run;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      lost_ff   <= 1'b0;
      fail_ff   <= 1'b0;
      locked_ff <= 1'b0;
    end else begin
      if (lost_set) begin
        lost_ff <= 1'b1;
      end else if (wr_stat && !I_REG_REQ.wdata[`DCDL_STAT_LOST_BIT]) begin
        lost_ff <= 1'b0;
      end
      fail_ff   <= nxt_state == ST_FAIL;
      locked_ff <= nxt_state == ST_LOCK;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // All outputs are registered; the fine line is held at its midpoint
  // because only the coarse line is walked by the search.
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      coarse_out_ff <= `DCDL_RST_COARSE;
      fine_out_ff   <= `DCDL_FINE_FIXED;
      rdata_ff      <= 8'h00;
      rvalid_ff     <= 1'b0;
    end else begin
      coarse_out_ff <= loop_en ? nxt_loop_crs : coarse_sp_ff;
      fine_out_ff   <= `DCDL_FINE_FIXED;
      rvalid_ff     <= I_REG_REQ.rd;
      if (I_REG_REQ.rd) rdata_ff <= rd_mux;
    end
  end

  assign O_REG_RDATA       = rdata_ff;
  assign O_REG_RVALID      = rvalid_ff;
  assign O_LOOP_PD         = pwr_ff[`DCDL_PWR_PD_BIT];
  // Field order of the struct matches bits 4 down to 1 of the register
  assign O_LINE_EN         = dcdl_line_en_s'(pwr_ff[`DCDL_PWR_FDC_BIT:`DCDL_PWR_CXC_BIT]);
  assign O_COARSE_DELAY    = coarse_out_ff;
  assign O_FINE_DELAY      = fine_out_ff;
  assign O_LOCKED          = locked_ff;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  property p_pd_stops_loop;
    loop_pd |=> state_ff == ST_IDLE && !locked_ff;
  endproperty
  a_pd_stops_loop: assert property (p_pd_stops_loop)
    else $error("loop active while powered down");

  property p_line_en_follow;
    wr_pwr |=> O_LINE_EN == {$past(I_REG_REQ.wdata[4:1])};
  endproperty
  a_line_en_follow: assert property (p_line_en_follow)
    else $error("line enables did not take written value");

  property p_coarse_en_follow;
    wr_pwr && I_REG_REQ.wdata[2:1] == 2'b00 |=> !O_LINE_EN.coarse_dc && !O_LINE_EN.coarse_xc;
  endproperty
  a_coarse_en_follow: assert property (p_coarse_en_follow)
    else $error("coarse line enables not cleared");

  property p_up_only;
    state_ff == ST_IDLE && run && srch_dir == `DCDL_SRCH_UP |=> state_ff == ST_UP;
  endproperty
  a_up_only: assert property (p_up_only)
    else $error("up-only search did not start upward");

  property p_static_path;
    (!loop_en && !wr_ctrl && !wr_coarse) [*2] |-> O_COARSE_DELAY == coarse_sp_ff;
  endproperty
  a_static_path: assert property (p_static_path)
    else $error("static setpoint not applied");

  property p_fail_flag;
    $rose(fail_ff) |-> !$past(I_PHASE_MATCH) && stat_rd[`DCDL_STAT_FAIL_BIT] &&
      (O_COARSE_DELAY == 6'h00 || O_COARSE_DELAY == 6'h3f);
  endproperty
  a_fail_flag: assert property (p_fail_flag)
    else $error("fail flag without failed search");

  property p_lost_set;
    lost_set |=> lost_ff;
  endproperty
  a_lost_set: assert property (p_lost_set)
    else $error("lost lock not flagged");

  property p_lock_flag;
    O_LOCKED |-> $past(I_PHASE_MATCH) && $past(run) && stat_rd[`DCDL_STAT_LOCK_BIT];
  endproperty
  a_lock_flag: assert property (p_lock_flag)
    else $error("lock flag shown without phase match");

  property p_coarse_sp;
    wr_coarse |=> coarse_sp_ff == $past(I_REG_REQ.wdata[5:0]);
  endproperty
  a_coarse_sp: assert property (p_coarse_sp)
    else $error("coarse setpoint not written");

  property p_readback;
    rd_rise |=> rb_crs_ff == $past(coarse_out_ff) && rb_phs_ff == $past(I_PHASE_MEAS);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback not captured on request");

  property p_lost_sticky;
    lost_ff && !(wr_stat && !I_REG_REQ.wdata[1]) |=> lost_ff;
  endproperty
  a_lost_sticky: assert property (p_lost_sticky)
    else $error("lost flag cleared without software write");

endmodule : dcdl_ctrl
`default_nettype wire

//--- hdl/dcdl_params.svh
// Constants for the converter clock delay loop controller: register
// offsets, field positions, reset values and timing counts.
// Assumes a 125 MHz core clock and a 12-bit register address space.
`ifndef DCDL_PARAMS_SVH
`define DCDL_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DCDL_ADDR_PWR      12'h090
`define DCDL_ADDR_CTRL     12'h091
`define DCDL_ADDR_STAT     12'h092
`define DCDL_ADDR_GUARD    12'h093
`define DCDL_ADDR_COARSE   12'h094
`define DCDL_ADDR_READ     12'h098
`define DCDL_ADDR_RB_CRS   12'h099
`define DCDL_ADDR_RB_FINE  12'h09a
`define DCDL_ADDR_RB_PHS   12'h09b

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define DCDL_PWR_PD_BIT    0
`define DCDL_PWR_CXC_BIT   1
`define DCDL_PWR_CDC_BIT   2
`define DCDL_PWR_FXC_BIT   3
`define DCDL_PWR_FDC_BIT   4
`define DCDL_RST_PWR       5'h1f
`define DCDL_CTRL_EN_BIT   0
`define DCDL_CTRL_SRCH_LO  3
`define DCDL_RST_CTRL      8'hf4
`define DCDL_STAT_LOCK_BIT 0
`define DCDL_STAT_LOST_BIT 1
`define DCDL_STAT_FAIL_BIT 2
`define DCDL_RST_GUARD     4'h0
`define DCDL_RST_COARSE    6'h00
`define DCDL_FINE_FIXED    8'h80
`define DCDL_SRCH_DN       2'b00
`define DCDL_SRCH_UP       2'b01
`define DCDL_SRCH_BOTH     2'b10

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DCDL_CLK_NS        8
`define DCDL_STEP_NS       64
`define DCDL_STEP_CYC      ((`DCDL_STEP_NS + `DCDL_CLK_NS - 1) / `DCDL_CLK_NS)

`endif

//--- hdl/dcdl_pkg.sv
// Types shared by the delay loop controller and its surroundings.
// Assumes the constants header is included where offsets are needed.
package dcdl_pkg;

  // Controller sequence states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DOWN,
    ST_UP,
    ST_LOCK,
    ST_FAIL
  } dcdl_state_e;

  // One register access from the configuration port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } dcdl_reg_req_s;

  // Duty-cycle and cross control enables of both delay lines
  typedef struct packed {
    logic fine_dc;
    logic fine_xc;
    logic coarse_dc;
    logic coarse_xc;
  } dcdl_line_en_s;

endpackage : dcdl_pkg

//--- dv/testbench.sv
// Self-checking testbench for the delay loop controller: register map,
// readback capture, lock, lost-lock and failed-search status.
// Assumes the constants header and package are compiled first; no partner model.
`timescale 1ns/100ps
`default_nettype none
`include "dcdl_params.svh"

module testbench;
  import dcdl_pkg::*;

  // ----------------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------------
  localparam int STEP = 2;      // Short settle per step keeps the search quick
  localparam int TMO  = 20000;  // Whole run needs well under a thousand cycles

  logic          clk;
  logic          rst;
  dcdl_reg_req_s req;
  logic          match;
  logic [4:0]    meas;
  logic [7:0]    rdata;
  logic          rvalid;
  logic          loop_pd;
  dcdl_line_en_s line_en;
  logic [5:0]    coarse;
  logic [7:0]    fine;
  logic          locked;
  int            fail_count;
  int            compares;
  int            cyc = 0;
  int            mdl [int];     // Bench copy of every stored register
  int            adr_q [$];
  logic [7:0]    rv;

  dcdl_ctrl #(.STEP_CYC(STEP)) dcdl_ctrl_inst (
    .I_CORE_CLK     (clk),
    .I_RST          (rst),
    .I_REG_REQ      (req),
    .I_PHASE_MATCH  (match),
    .I_PHASE_MEAS   (meas),
    .O_REG_RDATA    (rdata),
    .O_REG_RVALID   (rvalid),
    .O_LOOP_PD      (loop_pd),
    .O_LINE_EN      (line_en),
    .O_COARSE_DELAY (coarse),
    .O_FINE_DELAY   (fine),
    .O_LOCKED       (locked)
  );

  // ----------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hang counts as a mismatch rather than running forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Stored bits of each writable register; zero marks read-only or unmapped
  function automatic int msk(input int a);
    case (a)
      `DCDL_ADDR_PWR:    return 8'h1f;
      `DCDL_ADDR_CTRL:   return 8'hff;
      `DCDL_ADDR_GUARD:  return 8'h0f;
      `DCDL_ADDR_COARSE: return 8'h3f;
      `DCDL_ADDR_READ:   return 8'h01;
      default:           return 0;
    endcase
  endfunction : msk

  function automatic logic [7:0] ex(input int a);
    return mdl.exists(a) ? 8'(mdl[a]) : 8'h00;
  endfunction : ex

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask : wr

  // Read data and valid stand in the cycle after the strobe is taken
  task automatic chk_reg(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk($sformatf("reg %h", a), exp, rdata);
    req = '0;
  endtask : chk_reg

  // Write through the port and track it in the bench copy
  task automatic put(input logic [11:0] a, input logic [7:0] d);
    if (a == `DCDL_ADDR_READ && d[0] && ex(a) == 8'h00) begin
      mdl[`DCDL_ADDR_RB_CRS]  = ex(`DCDL_ADDR_COARSE);
      mdl[`DCDL_ADDR_RB_FINE] = 8'h80;
      mdl[`DCDL_ADDR_RB_PHS]  = meas;
    end
    if (msk(a) != 0) mdl[a] = d & msk(a);
    wr(a, d);
  endtask : put

  task automatic wait_lock();
    int n;
    n = 0;
    while (locked !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("locked", 8'h01, {7'h00, locked});
  endtask : wait_lock

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    match = 1'b0;
    meas = 5'h00;
    fail_count = 0;
    compares = 0;
    mdl[`DCDL_ADDR_PWR] = 8'h1f;
    mdl[`DCDL_ADDR_CTRL] = 8'hf4;
    void'($urandom(32'h5884));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("pd", 8'h01, {7'h00, loop_pd});
    chk("line_en", 8'h0f, {4'h0, line_en});
    chk("coarse", 8'h00, {2'h0, coarse});
    chk("fine", 8'h80, fine);
    chk("locked", 8'h00, {7'h00, locked});
    // Reset values, unmapped places included, read as zero where not stored
    adr_q = '{12'h090, 12'h091, 12'h092, 12'h093, 12'h094, 12'h098, 12'h099, 12'h09b, 12'h0a5};
    foreach (adr_q[i]) chk_reg(12'(adr_q[i]), ex(adr_q[i]));
    // Random power and line enables reach the pins
    repeat (4) begin
      put(`DCDL_ADDR_PWR, 8'($urandom));
      chk_reg(`DCDL_ADDR_PWR, ex(`DCDL_ADDR_PWR));
      chk("pd", 8'(mdl[`DCDL_ADDR_PWR] & 1), {7'h00, loop_pd});
      chk("line_en", 8'(mdl[`DCDL_ADDR_PWR] >> 1), {4'h0, line_en});
    end
    // Static setpoint drives the coarse line while the loop is off
    repeat (4) begin
      put(`DCDL_ADDR_COARSE, 8'($urandom));
      chk_reg(`DCDL_ADDR_COARSE, ex(`DCDL_ADDR_COARSE));
      chk("coarse", ex(`DCDL_ADDR_COARSE), {2'h0, coarse});
    end
    put(`DCDL_ADDR_GUARD, 8'($urandom));
    chk_reg(`DCDL_ADDR_GUARD, ex(`DCDL_ADDR_GUARD));
    for (int c = 0; c < 3; c++) begin
      put(`DCDL_ADDR_CTRL, 8'(c << 3));
      chk_reg(`DCDL_ADDR_CTRL, ex(`DCDL_ADDR_CTRL));
    end
    // Read-only places ignore writes
    wr(`DCDL_ADDR_STAT, 8'hff);
    wr(`DCDL_ADDR_RB_CRS, 8'hff);
    chk_reg(`DCDL_ADDR_STAT, 8'h00);
    chk_reg(`DCDL_ADDR_RB_CRS, 8'h00);
    // Capture happens on a 0 to 1 change only, not on a repeated 1
    for (int k = 0; k < 2; k++) begin
      meas = 5'($urandom);
      put(`DCDL_ADDR_READ, 8'h01);
      meas = ~meas;
      put(`DCDL_ADDR_READ, 8'h01);
      chk_reg(`DCDL_ADDR_RB_CRS, ex(`DCDL_ADDR_RB_CRS));
      chk_reg(`DCDL_ADDR_RB_FINE, 8'h80);
      chk_reg(`DCDL_ADDR_RB_PHS, ex(`DCDL_ADDR_RB_PHS));
      put(`DCDL_ADDR_READ, 8'h00);
    end
    // Lock, loss of lock, and a sticky lost flag across relock
    put(`DCDL_ADDR_COARSE, 8'h05);
    put(`DCDL_ADDR_PWR, 8'h1e);
    match = 1'b1;
    put(`DCDL_ADDR_CTRL, 8'h11);
    wait_lock();
    chk("coarse", 8'h05, {2'h0, coarse});
    chk_reg(`DCDL_ADDR_STAT, 8'h01);
    @(negedge clk);
    match = 1'b0;
    repeat (3) @(negedge clk);
    chk("locked", 8'h00, {7'h00, locked});
    chk_reg(`DCDL_ADDR_STAT, 8'h02);
    match = 1'b1;
    wait_lock();
    chk_reg(`DCDL_ADDR_STAT, 8'h03);
    put(`DCDL_ADDR_STAT, 8'h00);
    chk_reg(`DCDL_ADDR_STAT, 8'h01);
    put(`DCDL_ADDR_CTRL, 8'h00);
    put(`DCDL_ADDR_STAT, 8'h00);
    chk_reg(`DCDL_ADDR_STAT, 8'h00);
    // Failed searches: down only, up only, then both ways
    match = 1'b0;
    put(`DCDL_ADDR_COARSE, 8'h02);
    put(`DCDL_ADDR_CTRL, 8'h01);
    repeat (40) @(negedge clk);
    chk_reg(`DCDL_ADDR_STAT, 8'h04);
    chk("coarse", 8'h00, {2'h0, coarse});
    put(`DCDL_ADDR_CTRL, 8'h00);
    put(`DCDL_ADDR_COARSE, 8'h3c);
    put(`DCDL_ADDR_CTRL, 8'h09);
    repeat (40) @(negedge clk);
    chk_reg(`DCDL_ADDR_STAT, 8'h04);
    chk("coarse", 8'h3f, {2'h0, coarse});
    put(`DCDL_ADDR_CTRL, 8'h00);
    put(`DCDL_ADDR_COARSE, 8'h01);
    put(`DCDL_ADDR_CTRL, 8'h11);
    repeat (40) @(negedge clk);
    chk_reg(`DCDL_ADDR_STAT, 8'h00);
    repeat (300) @(negedge clk);
    chk_reg(`DCDL_ADDR_STAT, 8'h04);
    put(`DCDL_ADDR_CTRL, 8'h00);
    chk_reg(`DCDL_ADDR_STAT, 8'h00);
    chk("coarse", 8'h01, {2'h0, coarse});
    // Power-down keeps the loop from locking even when enabled
    put(`DCDL_ADDR_PWR, 8'h1f);
    match = 1'b1;
    put(`DCDL_ADDR_CTRL, 8'h11);
    repeat (20) @(negedge clk);
    chk("locked", 8'h00, {7'h00, locked});
    chk_reg(`DCDL_ADDR_STAT, 8'h00);
    end_sim();
  end

endmodule : testbench
`default_nettype wire
